// *** core/gsp_params.svh ***
/*
  Constants for the global sector protect decode: status byte field
  positions, patterns, reset values and the sector count.
  Assumes it is included by bare name from core files only.
*/
// Functional notes
// - Unlocked, pattern 0000 in bits 5:2 clears all sector flags; lock follows bit 7.
// - Unlocked, pattern 1111 in bits 5:2 sets all sector flags; lock follows bit 7.
// - Mixed pattern in bits 5:2 leaves sector flags; lock follows bit 7 if unlocked.
// - Writing all ones while unlocked protects everything and sets lock together.
// - Pin high and locked: bit 7 clear clears lock, sector flags untouched.
// - Bit 7 set with mixed pattern while unlocked sets lock only.
// - Pin low and locked: whole write ignored, lock and sector flags unchanged, write latch still clears.
// - Pin high and locked: no global operation, lock takes written bit 7.
// - Bits 5:2 are decoded only, never stored; only bit 7 is kept.
// - Read bits 4:2 show pin state and protection summary, bit 5 reads zero; none is written data.
// - One protection flag per sector, one meaning protected.
// - Every sector flag resets to one, all sectors protected.
// - Status write runs only when the write latch was set beforehand.
`ifndef GSP_PARAMS_SVH
`define GSP_PARAMS_SVH

`define GSP_SECTORS 16
`define GSP_LOCK_BIT 7
`define GSP_PAT_HI 5
`define GSP_PAT_LO 2
`define GSP_PAT_ALL1 4'hf
`define GSP_PAT_ALL0 4'h0
`define GSP_SR_ERR_BIT 5
`define GSP_SR_WP_BIT 4
`define GSP_SR_SUM_HI 3
`define GSP_SR_SUM_LO 2
`define GSP_SR_LATCH_BIT 1
`define GSP_SR_BUSY_BIT 0
`define GSP_SUM_NONE 2'h0
`define GSP_SUM_SOME 2'h1
`define GSP_SUM_ALL 2'h3
`define GSP_SECTOR_RST 1'h1
`define GSP_LOCK_RST 1'h0
`define GSP_LATCH_RST 1'h0

`endif

// *** core/gsp_pkg.sv ***
/*
  Types for the global sector protect decode.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package gsp_pkg;
  typedef enum logic [2:0] {
    GSP_OP_NONE,
    GSP_OP_UNPROT,
    GSP_OP_PROT,
    GSP_OP_LOCK_ONLY,
    GSP_OP_IGNORED,
    GSP_OP_NO_LATCH
  } gsp_op_e;

  typedef enum logic {
    GSP_ST_IDLE,
    GSP_ST_APPLY
  } gsp_state_e;
endpackage

// *** core/gsp_decode_if.sv ***
/*
  Carrier between the control module and its byte decoder.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
interface gsp_decode_if;
  logic [7:0] wr_byte;
  logic lock_now;
  logic wp_asserted;
  logic do_protect;
  logic do_unprotect;
  logic lock_next;
  logic ignored;

  modport ctrl (output wr_byte, output lock_now, output wp_asserted,
                input do_protect, input do_unprotect, input lock_next, input ignored);
  modport dec (input wr_byte, input lock_now, input wp_asserted,
               output do_protect, output do_unprotect, output lock_next, output ignored);
endinterface

// *** core/gsp_byte_decode.sv ***
/*
  Combinational decode of a written first status byte into the global
  protect action and the next lock value.
  Assumes a synchronised pin level and the present lock value as inputs.
*/
`timescale 1ns/1ps
`include "gsp_params.svh"
module gsp_byte_decode
  import gsp_pkg::*;
(
  gsp_decode_if.dec dif
);
  // ==========================================================
  // Decode
  // ==========================================================
  logic [3:0] pattern;
  logic wr_lock;
  logic hw_locked;

  // Only bits 7 and 5:2 are looked at
  assign pattern = dif.wr_byte[`GSP_PAT_HI:`GSP_PAT_LO];
  assign wr_lock = dif.wr_byte[`GSP_LOCK_BIT];
  assign hw_locked = dif.wp_asserted & dif.lock_now;

  always_comb begin
    dif.do_protect = 1'b0;
    dif.do_unprotect = 1'b0;
    dif.lock_next = dif.lock_now;
    dif.ignored = 1'b0;
    if (hw_locked) begin
      dif.ignored = 1'b1;
    end else if (dif.lock_now) begin
      // Soft lock: registers stay frozen until this write has finished
      dif.lock_next = wr_lock;
    end else begin
      dif.lock_next = wr_lock;
      dif.do_protect = (pattern == `GSP_PAT_ALL1);
      dif.do_unprotect = (pattern == `GSP_PAT_ALL0);
    end
  end
endmodule

// *** core/gsp_ctrl.sv ***
/*
  Global sector protect control: write latch, lock bit, per-sector
  protection flags and the readable first status byte.
  Assumes command framing logic on sys_clk_in delivers one-cycle strobes
  at chip-select release; the write-protect pin is asynchronous.
*/
`timescale 1ns/1ps
`include "gsp_params.svh"
module gsp_ctrl
  import gsp_pkg::*;
#(
  parameter int SECTORS = `GSP_SECTORS
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic wp_b_in,
  input wire logic wr_enable_in,
  input wire logic wr_disable_in,
  input wire logic status_wr_in,
  input wire logic [7:0] status_byte_in,
  output logic busy_out,
  output logic done_out,
  output logic [2:0] last_op_out,
  output logic protection_lock_bit_out,
  output logic write_latch_bit_out,
  output logic [SECTORS-1:0] sector_prot_out,
  output logic [7:0] status_rd_out
);
  // ==========================================================
  // Write-protect pin synchroniser
  // ==========================================================
  logic wp_b_meta_reg;
  logic wp_b_sync_reg;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wp_b_meta_reg <= 1'h1;
      wp_b_sync_reg <= 1'h1;
    end else begin
      wp_b_meta_reg <= wp_b_in;
      wp_b_sync_reg <= wp_b_meta_reg;
    end
  end

  // ==========================================================
  // Sequencing
  // ==========================================================
  gsp_state_e state_reg;
  logic [7:0] byte_reg;
  logic take;
  logic write_latch_bit_reg;
  logic protection_lock_bit_reg;
  logic [SECTORS-1:0] sector_prot_reg;

  // A second write during the apply cycle is dropped; framing logic
  // cannot produce two releases that close together anyway.
  assign busy_out = (state_reg == GSP_ST_APPLY);
  assign take = status_wr_in && (state_reg == GSP_ST_IDLE);

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= GSP_ST_IDLE;
    end else begin
      unique case (state_reg)
        GSP_ST_IDLE: begin
          if (take && write_latch_bit_reg) begin
            state_reg <= GSP_ST_APPLY;
          end
        end
        GSP_ST_APPLY: begin
          state_reg <= GSP_ST_IDLE;
        end
      endcase
    end
  end

  // Held only for the decode; never reaches the status read path
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      byte_reg <= 8'h00;
    end else if (take) begin
      byte_reg <= status_byte_in;
    end
  end

  // ==========================================================
  // Write enable latch
  // ==========================================================
  // Enable wins over a same-cycle clear so the host's request is not lost
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      write_latch_bit_reg <= `GSP_LATCH_RST;
    end else if (wr_enable_in) begin
      write_latch_bit_reg <= 1'h1;
    end else if (wr_disable_in || take) begin
      write_latch_bit_reg <= 1'h0;
    end
  end

  // ==========================================================
  // Decoder
  // ==========================================================
  gsp_decode_if dif ();

  assign dif.wr_byte = byte_reg;
  assign dif.lock_now = protection_lock_bit_reg;
  assign dif.wp_asserted = !wp_b_sync_reg;

  gsp_byte_decode u_dec (
    .dif(dif)
  );

  // ==========================================================
  // Lock bit and sector flags
  // ==========================================================
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      protection_lock_bit_reg <= `GSP_LOCK_RST;
    end else if (state_reg == GSP_ST_APPLY) begin
      protection_lock_bit_reg <= dif.lock_next;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < SECTORS; gi++) begin : g_sector
      always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          sector_prot_reg[gi] <= `GSP_SECTOR_RST;
        end else if (state_reg == GSP_ST_APPLY) begin
          if (dif.do_protect) begin
            sector_prot_reg[gi] <= 1'h1;
          end else if (dif.do_unprotect) begin
            sector_prot_reg[gi] <= 1'h0;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // Result reporting
  // ==========================================================
  gsp_op_e last_op_reg;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      done_out <= 1'h0;
      last_op_reg <= GSP_OP_NONE;
    end else begin
      done_out <= (state_reg == GSP_ST_APPLY) || (take && !write_latch_bit_reg);
      if (take && !write_latch_bit_reg) begin
        last_op_reg <= GSP_OP_NO_LATCH;
      end else if (state_reg == GSP_ST_APPLY) begin
        if (dif.ignored) begin
          last_op_reg <= GSP_OP_IGNORED;
        end else if (dif.do_protect) begin
          last_op_reg <= GSP_OP_PROT;
        end else if (dif.do_unprotect) begin
          last_op_reg <= GSP_OP_UNPROT;
        end else begin
          last_op_reg <= GSP_OP_LOCK_ONLY;
        end
      end
    end
  end

  assign last_op_out = last_op_reg;
  assign protection_lock_bit_out = protection_lock_bit_reg;
  assign write_latch_bit_out = write_latch_bit_reg;
  assign sector_prot_out = sector_prot_reg;

  // ==========================================================
  // Status byte read image
  // ==========================================================
  logic [1:0] summary_next;

  always_comb begin
    if (&sector_prot_reg) begin
      summary_next = `GSP_SUM_ALL;
    end else if (|sector_prot_reg) begin
      summary_next = `GSP_SUM_SOME;
    end else begin
      summary_next = `GSP_SUM_NONE;
    end
  end

  // Bits 4:2 come from live state and bit 5 reads zero, never from written data
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      status_rd_out <= 8'h00;
    end else begin
      status_rd_out <= 8'h00;
      status_rd_out[`GSP_LOCK_BIT] <= protection_lock_bit_reg;
      status_rd_out[`GSP_SR_WP_BIT] <= wp_b_sync_reg;
      status_rd_out[`GSP_SR_SUM_HI:`GSP_SR_SUM_LO] <= summary_next;
      status_rd_out[`GSP_SR_LATCH_BIT] <= write_latch_bit_reg;
      status_rd_out[`GSP_SR_BUSY_BIT] <= busy_out;
    end
  end
endmodule

// *** test/gsp_ctrl_props.sv ***
/* Port checker for gsp_ctrl, bound below to every instance.
   Assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/1ps
module gsp_ctrl_props #(parameter int SECTORS = 16) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic status_wr_in,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic [2:0] last_op_out,
  input wire logic protection_lock_bit_out,
  input wire logic write_latch_bit_out,
  input wire logic [SECTORS-1:0] sector_prot_out,
  input wire logic [7:0] status_rd_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  wire take = status_wr_in && !busy_out;
  // ====
  // Write outcomes, read image and reset values
  apply_timing_a: assert property (
    take && write_latch_bit_out |=> busy_out ##1 done_out) else $error("late apply");
  no_latch_a: assert property (
    take && !write_latch_bit_out |=> done_out && last_op_out == 3'h5 &&
    $stable(sector_prot_out)) else $error("write ran without latch");
  unprot_all_a: assert property (
    done_out && last_op_out == 3'h1 |-> sector_prot_out == '0) else $error("unprotect");
  prot_all_a: assert property (
    done_out && last_op_out == 3'h2 |-> &sector_prot_out) else $error("protect");
  keep_flags_a: assert property (
    done_out && last_op_out inside {3'h3, 3'h4} |-> $stable(sector_prot_out))
    else $error("flags moved");
  hw_lock_a: assert property (
    done_out && last_op_out == 3'h4 |-> $stable(protection_lock_bit_out))
    else $error("lock moved");
  summary_img_a: assert property (
    $past(rst_b_in) |-> status_rd_out[3:2] == (&$past(sector_prot_out) ? 2'h3 :
    (|$past(sector_prot_out) ? 2'h1 : 2'h0))) else $error("summary");
  reset_val_a: assert property (
    $rose(rst_b_in) |-> &sector_prot_out && !protection_lock_bit_out) else $error("reset");
endmodule
bind gsp_ctrl gsp_ctrl_props #(.SECTORS(SECTORS)) u_props (.sys_clk_in, .rst_b_in,
  .status_wr_in, .busy_out, .done_out, .last_op_out, .protection_lock_bit_out,
  .write_latch_bit_out, .sector_prot_out, .status_rd_out);

// *** test/gsp_host_model.sv ***
/* Host model issuing write enable and one status byte write.
   Assumes it shares the controller clock. */
`timescale 1ns/1ps
module gsp_host_model (
  input wire logic clk_in,
  input wire logic done_in,
  output logic wr_enable_out = 1'h0,
  output logic status_wr_out = 1'h0,
  output logic [7:0] status_byte_out = 8'h00
);
  // ====
  // Transfer
  task automatic enable_only();
    @(negedge clk_in);
    wr_enable_out = 1'h1;
    @(negedge clk_in);
    wr_enable_out = 1'h0;
  endtask
  task automatic write_status(input logic [7:0] b, input logic write_latch_bit, output bit ok);
    int n;
    @(negedge clk_in);
    wr_enable_out = write_latch_bit;
    @(negedge clk_in);
    wr_enable_out = 1'h0;
    status_wr_out = 1'h1;
    status_byte_out = b;
    @(negedge clk_in);
    status_wr_out = 1'h0;
    // Released byte is inverted so a late sample cannot look right
    status_byte_out = ~b;
    ok = done_in;
    for (n = 0; n < 4 && !ok; n++) begin
      @(negedge clk_in);
      ok = done_in;
    end
  endtask
endmodule

// *** test/global_sector_protect_decode_tb.sv ***
/* Bench for gsp_ctrl: table of status writes, then hand tests.
   Assumes the host model and the bound checker. */
`timescale 1ns/1ps
module global_sector_protect_decode_tb;
  import gsp_pkg::*;
  localparam int NS = 8;
  // Row: {wp_b, lock before, flags after, lock after, byte}
  localparam logic [11:0] ROWS [14] = '{
    12'h800,
    12'ha7f,
    12'h804,
    12'h838,
    12'hbff,
    12'h3ff,
    12'hc0f,
    12'hc3c,
    12'h9f0,
    12'h57c,
    12'h500,
    12'hdbc,
    12'ha3c,
    12'h847
  };
  logic sys_clk_in = 1'h0;
  logic rst_b_in = 1'h0;
  logic wp_b_in = 1'h1;
  logic wr_disable_in = 1'h0;
  logic wr_enable_in, status_wr_in, busy_out, done_out, protection_lock_bit_out;
  logic write_latch_bit_out;
  logic [7:0] status_byte_in, status_rd_out;
  logic [2:0] last_op_out;
  logic [NS-1:0] sector_prot_out;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  gsp_ctrl #(.SECTORS(NS)) dut (.sys_clk_in, .rst_b_in, .wp_b_in, .wr_enable_in,
    .wr_disable_in, .status_wr_in, .status_byte_in, .busy_out, .done_out,
    .last_op_out, .protection_lock_bit_out, .write_latch_bit_out, .sector_prot_out,
    .status_rd_out);
  gsp_host_model host (.clk_in(sys_clk_in), .done_in(done_out),
    .wr_enable_out(wr_enable_in), .status_wr_out(status_wr_in),
    .status_byte_out(status_byte_in));
  // ====
  // Helpers
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'h1) begin
      num_errors++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [7:0] b, input logic write_latch_bit);
    bit ok;
    host.write_status(b, write_latch_bit, ok);
    check(ok, "no done");
  endtask
  task automatic expect_state(input logic s, input logic l);
    check(sector_prot_out === {NS{s}} && protection_lock_bit_out === l, "state");
  endtask
  // Two sync flops plus the read image lag
  task automatic set_wp(input logic v);
    wp_b_in = v;
    repeat (3) @(negedge sys_clk_in);
  endtask
  // Whole run is a few hundred cycles
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (20) @(negedge sys_clk_in);
    rst_b_in = 1'h1;
    @(negedge sys_clk_in);
    check(sector_prot_out === '1 && protection_lock_bit_out === 1'h0, "reset");
    check(status_rd_out === 8'h1c, "reset image");
    $display("reset test done");
    foreach (ROWS[i]) begin
      set_wp(1'h1);
      wr(8'h00, 1'h1);
      wr({ROWS[i][10], 7'h00}, 1'h1);
      set_wp(ROWS[i][11]);
      wr(ROWS[i][7:0], 1'h1);
      expect_state(ROWS[i][9], ROWS[i][8]);
      $display("row %0d done", i);
    end
    set_wp(1'h1);
    wr(8'h00, 1'h1);
    wr(8'h80, 1'h1);
    wr(8'h7f, 1'h1);
    expect_state(1'h0, 1'h0);
    wr(8'h7f, 1'h1);
    expect_state(1'h1, 1'h0);
    $display("two step test done");
    @(negedge sys_clk_in);
    check(status_rd_out[7:2] === 6'h07, "image");
    set_wp(1'h0);
    check(status_rd_out[4] === 1'h0, "pin image");
    $display("image test done");
    wr(8'h00, 1'h0);
    expect_state(1'h1, 1'h0);
    check(last_op_out === GSP_OP_NO_LATCH && write_latch_bit_out === 1'h0, "latch");
    $display("no latch test done");
    host.enable_only();
    check(write_latch_bit_out === 1'h1, "latch set");
    wr_disable_in = 1'h1;
    @(negedge sys_clk_in);
    wr_disable_in = 1'h0;
    check(write_latch_bit_out === 1'h0, "latch cleared");
    $display("disable test done");
    // Leave flags clear and lock set so the mid-run reset has work to undo
    wr(8'h00, 1'h1);
    wr(8'h80, 1'h1);
    expect_state(1'h0, 1'h1);
    rst_b_in = 1'h0;
    repeat (2) @(negedge sys_clk_in);
    rst_b_in = 1'h1;
    @(negedge sys_clk_in);
    expect_state(1'h1, 1'h0);
    check(write_latch_bit_out === 1'h0 && status_rd_out === 8'h1c, "mid reset");
    $display("mid reset test done");
    stop_test();
  end
endmodule
